// file: verilog/cbsp_defs.vh
// register map, field positions and timing counts of the socket power block
`ifndef CBSP_DEFS_VH
`define CBSP_DEFS_VH
`define CBSP_OFF_SUPPLY_CTRL 8'h10
`define CBSP_OFF_POWER_MGMT 8'h20
`define CBSP_SUPPLY_CTRL_RESET 32'h00000000
`define CBSP_POWER_MGMT_RESET 32'h00000000
`define CBSP_BIT_STOP_POLICY 7
`define CBSP_CORE_LSB 4
`define CBSP_CORE_MSB 6
`define CBSP_PROG_LSB 0
`define CBSP_PROG_MSB 2
`define CBSP_BIT_CLK_CTRL_EN 16
`define CBSP_BIT_IDLE_ACTION 0
`define CBSP_BIT_SOCKET_ACCESS 25
`define CBSP_BIT_SOCKET_MODE 24
`define CBSP_IDLE_CLOCKS 4'h8
`define CBSP_SLOW_DIVIDE 5'h10
`define CBSP_SUPPLY_OFF 3'h0
`define CBSP_CORE_5V0 3'h2
`define CBSP_CORE_3V3 3'h3
`define CBSP_CORE_ALT_X 3'h4
`define CBSP_CORE_ALT_Y 3'h5
`define CBSP_PROG_12V0 3'h1
`define CBSP_PROG_5V0 3'h2
`define CBSP_PROG_3V3 3'h3
`define CBSP_PROG_ALT_X 3'h4
`define CBSP_PROG_ALT_Y 3'h5
`endif

// file: verilog/cbsp_socket_power_clock.v
// socket supply request and card clock stop/slow control
`timescale 1ns/1ps
`default_nettype none
`include "cbsp_defs.vh"
module cbsp_socket_power_clock (
    input wire clock,
    input wire rst_n,
    input wire bus_reset_pin_n,
    input wire wake_event_enable,
    input wire [7:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    input wire [3:0] avs_byteenable,
    output reg [31:0] avs_readdata,
    output reg avs_waitrequest,
    input wire card_idle,
    input wire host_clock_stop_req,
    output reg card_clock_pin,
    output reg card_clock_stopped,
    output reg card_clock_slowed,
    output reg [2:0] core_supply_request,
    output reg [2:0] program_supply_request
);
    localparam ST_RUN = 2'h0;
    localparam ST_STOP = 2'h1;
    localparam ST_SLOW = 2'h2;

    reg clock_stop_policy_q;
    reg card_clock_ctrl_enable_q;
    reg idle_clock_action_q;
    reg socket_access_q;
    reg [3:0] idle_cnt_q;
    reg [4:0] div_cnt_q;
    reg [1:0] state_q;
    reg [1:0] state_d;
    reg ack_q;
    wire req;
    wire idle_long;
    wire stop_ok;
    wire sel_ctrl;
    wire sel_pm;
    wire wr_take;
    wire rd_take;
    wire supply_clear;

    assign req = avs_read | avs_write;
    // one wait cycle: the answer is registered, so read data comes from flops
    assign wr_take = avs_write & ack_q;
    assign rd_take = avs_read & ack_q;
    assign sel_ctrl = (avs_address == `CBSP_OFF_SUPPLY_CTRL);
    assign sel_pm = (avs_address == `CBSP_OFF_POWER_MGMT);
    // a busy cycle cancels the run at once, so no stop lands on activity
    assign idle_long = card_idle & (idle_cnt_q == `CBSP_IDLE_CLOCKS);
    // host stop request only matters when the policy bit is clear
    assign stop_ok = idle_long &
        (clock_stop_policy_q | host_clock_stop_req);
    assign supply_clear = ~bus_reset_pin_n & ~wake_event_enable;

    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ack_q <= 1'b0;
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h00000000;
        end else begin
            ack_q <= req & ~ack_q;
            avs_waitrequest <= ~(req & ~ack_q);
            avs_readdata <= 32'h00000000;
            if (avs_read & ~ack_q) begin
                if (sel_ctrl) begin
                    // upper bits and bit 3 are left zero
                    avs_readdata[`CBSP_BIT_STOP_POLICY] <=
                        clock_stop_policy_q;
                    avs_readdata[`CBSP_CORE_MSB:`CBSP_CORE_LSB] <=
                        core_supply_request;
                    avs_readdata[`CBSP_PROG_MSB:`CBSP_PROG_LSB] <=
                        program_supply_request;
                end else if (sel_pm) begin
                    avs_readdata[`CBSP_BIT_SOCKET_ACCESS] <= socket_access_q;
                    avs_readdata[`CBSP_BIT_SOCKET_MODE] <= card_clock_slowed;
                    avs_readdata[`CBSP_BIT_CLK_CTRL_EN] <=
                        card_clock_ctrl_enable_q;
                    avs_readdata[`CBSP_BIT_IDLE_ACTION] <= idle_clock_action_q;
                end
            end
        end
    end

    // supply fields: global reset always, bus reset only if wake disabled
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            core_supply_request <= `CBSP_SUPPLY_OFF;
            program_supply_request <= `CBSP_SUPPLY_OFF;
        end else if (supply_clear) begin
            core_supply_request <= `CBSP_SUPPLY_OFF;
            program_supply_request <= `CBSP_SUPPLY_OFF;
        end else if (wr_take & sel_ctrl & avs_byteenable[0]) begin
            // reserved codes are stored as written; the power switch rejects
            core_supply_request <=
                avs_writedata[`CBSP_CORE_MSB:`CBSP_CORE_LSB];
            program_supply_request <=
                avs_writedata[`CBSP_PROG_MSB:`CBSP_PROG_LSB];
        end
    end

    // policy bit is not tied to the wake-enable reset scheme
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            clock_stop_policy_q <= 1'b0;
            card_clock_ctrl_enable_q <= 1'b0;
            idle_clock_action_q <= 1'b0;
            socket_access_q <= 1'b0;
        end else begin
            if (wr_take & sel_ctrl & avs_byteenable[0])
                clock_stop_policy_q <= avs_writedata[`CBSP_BIT_STOP_POLICY];
            if (wr_take & sel_pm & avs_byteenable[2])
                card_clock_ctrl_enable_q <=
                    avs_writedata[`CBSP_BIT_CLK_CTRL_EN];
            if (wr_take & sel_pm & avs_byteenable[0])
                idle_clock_action_q <= avs_writedata[`CBSP_BIT_IDLE_ACTION];
            // card activity sets, a read clears; activity wins the tie
            if (~card_idle)
                socket_access_q <= 1'b1;
            else if (rd_take & sel_pm)
                socket_access_q <= 1'b0;
        end
    end

    // idle run counter saturates at the threshold
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            idle_cnt_q <= 4'h0;
        end else if (~card_idle) begin
            idle_cnt_q <= 4'h0;
        end else if (!idle_long) begin
            idle_cnt_q <= idle_cnt_q + 4'h1;
        end
    end

    always @* begin
        state_d = state_q;
        case (state_q)
            ST_RUN: begin
                if (card_clock_ctrl_enable_q) begin
                    if (idle_clock_action_q & idle_long)
                        state_d = ST_SLOW;
                    else if (~idle_clock_action_q & stop_ok)
                        state_d = ST_STOP;
                end
            end
            ST_STOP: begin
                if (~card_idle | ~card_clock_ctrl_enable_q)
                    state_d = ST_RUN;
            end
            ST_SLOW: begin
                if (~card_idle | ~card_clock_ctrl_enable_q)
                    state_d = ST_RUN;
            end
            default: begin
                state_d = ST_RUN;
            end
        endcase
    end

    // clock pin toggles each cycle when running (clock/2 nominal);
    // slow mode toggles every 8 cycles so a full period is 16 clocks
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= ST_RUN;
            div_cnt_q <= 5'h00;
            card_clock_pin <= 1'b0;
            card_clock_stopped <= 1'b0;
            card_clock_slowed <= 1'b0;
        end else begin
            state_q <= state_d;
            card_clock_stopped <= (state_d == ST_STOP);
            card_clock_slowed <= (state_d == ST_SLOW);
            case (state_d)
                ST_RUN: begin
                    div_cnt_q <= 5'h00;
                    card_clock_pin <= ~card_clock_pin;
                end
                ST_STOP: begin
                    // park low so the card sees a clean stopped level
                    div_cnt_q <= 5'h00;
                    card_clock_pin <= 1'b0;
                end
                ST_SLOW: begin
                    if (div_cnt_q == ((`CBSP_SLOW_DIVIDE >> 1) - 5'h01)) begin
                        div_cnt_q <= 5'h00;
                        card_clock_pin <= ~card_clock_pin;
                    end else begin
                        div_cnt_q <= div_cnt_q + 5'h01;
                    end
                end
                default: begin
                    div_cnt_q <= 5'h00;
                    card_clock_pin <= 1'b0;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// file: verification/cbsp_card_model.sv
// card side model: busy bursts of a given length, idle otherwise
`timescale 1ns/1ps
`default_nettype none
module cbsp_card_model (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [3:0] burst,
    output logic card_idle
);
    logic [3:0] left_q;
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) left_q <= 4'h0;
        else if (burst != 4'h0) left_q <= burst;
        else if (left_q != 4'h0) left_q <= left_q - 4'h1;
    end
    assign card_idle = (left_q == 4'h0);
endmodule
`default_nettype wire

// file: verification/cbsp_spc_asserts.sv
// port checker for the socket power and clock block
`timescale 1ns/1ps
`default_nettype none
module cbsp_spc_asserts (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic bus_reset_pin_n,
    input wire logic wake_event_enable,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic card_idle,
    input wire logic card_clock_pin,
    input wire logic card_clock_stopped,
    input wire logic card_clock_slowed,
    input wire logic [2:0] core_supply_request,
    input wire logic [2:0] program_supply_request
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);
    logic [3:0] idle_q;
    // saturates so long idle spells never wrap back under eight
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) idle_q <= 4'h0;
        else if (!card_idle) idle_q <= 4'h0;
        else if (idle_q != 4'hF) idle_q <= idle_q + 4'h1;
    end
    a_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest
        |=> !avs_waitrequest) else $error("request not answered");
    a_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("wait low too long");
    a_ctrl_resv: assert property (avs_read && !avs_waitrequest &&
        avs_address == 8'h10 |-> avs_readdata[31:8] == 24'h0 &&
        !avs_readdata[3]) else $error("control reserved set");
    a_mgmt_resv: assert property (avs_read && !avs_waitrequest &&
        avs_address == 8'h20 |-> avs_readdata[31:26] == 6'h0 &&
        avs_readdata[23:17] == 7'h0 && avs_readdata[15:1] == 15'h0)
        else $error("mgmt reserved set");
    a_stop_idle: assert property ($rose(card_clock_stopped)
        |-> idle_q >= 4'h8) else $error("stop before idle run");
    a_stop_pin: assert property (card_clock_stopped
        |-> !card_clock_pin) else $error("stopped pin high");
    a_run_pin: assert property (rst_n && !card_clock_stopped
        && !card_clock_slowed ##1 !card_clock_stopped && !card_clock_slowed
        |-> $changed(card_clock_pin)) else $error("running pin stuck");
    a_mode_excl: assert property (card_clock_slowed
        |-> !card_clock_stopped) else $error("slow and stop");
    a_bus_clear: assert property (!bus_reset_pin_n && !wake_event_enable
        |=> core_supply_request == 3'h0 && program_supply_request == 3'h0)
        else $error("supply not cleared");
    a_supply_hold: assert property ($changed(core_supply_request)
        |-> $past(avs_write && !avs_waitrequest) ||
        $past(!bus_reset_pin_n && !wake_event_enable))
        else $error("supply changed alone");
    cover property ($rose(card_clock_stopped));
    cover property ($rose(card_clock_slowed));
    cover property (!bus_reset_pin_n && wake_event_enable);
endmodule
bind cbsp_socket_power_clock cbsp_spc_asserts u_chk (.*);
`default_nettype wire

// file: verification/cbsp_socket_power_clock_tb.sv
// self-checking bench for the socket power and clock block
`timescale 1ns/1ps
`default_nettype none
module cbsp_socket_power_clock_tb;
    logic clock = 1'h0, rst_n = 1'h0, bus_reset_pin_n = 1'h1;
    logic wake_event_enable = 1'h0, avs_read = 1'h0, avs_write = 1'h0;
    logic host_clock_stop_req = 1'h0;
    logic [7:0] avs_address = 8'h0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0] avs_byteenable = 4'hF, burst = 4'h0;
    wire [31:0] avs_readdata;
    wire [2:0] core_supply_request, program_supply_request;
    wire avs_waitrequest, card_idle, card_clock_pin;
    wire card_clock_stopped, card_clock_slowed;
    int num_errors = 0, check_count = 0;
    logic pin_was;
    int half;
    cbsp_socket_power_clock dut (.*);
    cbsp_card_model card (.*);
    initial forever #2.5 clock = ~clock;
    task test_done;
        $display("checks %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task chk(input string n, input logic [31:0] s, input logic [31:0] e);
        check_count++;
        if (s !== e) begin
            num_errors++;
            $display("wrong value %s exp %h seen %h", n, e, s);
        end
    endtask
    // one access; d is write data, or expected read data under mask m
    task acc(input logic rd, input logic [7:0] a, input logic [31:0] d,
        input logic [31:0] m);
        @(posedge clock);
        avs_address <= a;
        avs_writedata <= d;
        avs_read <= rd;
        avs_write <= !rd;
        do @(posedge clock); while (avs_waitrequest !== 1'h0);
        if (rd) chk("readdata", avs_readdata & m, d);
        avs_read <= 1'h0;
        avs_write <= 1'h0;
    endtask
    task tick(input int n);
        repeat (n) @(posedge clock);
    endtask
    initial begin
        tick(6);
        rst_n <= 1'h1;
        acc(1, 8'h10, 0, '1);
        acc(1, 8'h20, 0, 32'hFCFFFFFF);
        acc(0, 8'h30, '1, 0);
        acc(1, 8'h30, 0, '1);
        $display("reset test done");
        acc(0, 8'h10, '1, 0);
        acc(1, 8'h10, 32'hF7, '1);
        for (int i = 0; i < 8; i++) begin
            acc(0, 8'h10, 32'(i * 17), 0);
            tick(1);
            chk("core", core_supply_request, i);
            chk("prog", program_supply_request, i);
        end
        wake_event_enable <= 1'h1;
        bus_reset_pin_n <= 1'h0;
        tick(2);
        chk("core", core_supply_request, 7);
        wake_event_enable <= 1'h0;
        tick(2);
        chk("core", core_supply_request, 0);
        chk("prog", program_supply_request, 0);
        bus_reset_pin_n <= 1'h1;
        $display("supply test done");
        acc(0, 8'h20, '1, 0);
        acc(1, 8'h20, 32'h10001, 32'hFCFFFFFF);
        tick(12);
        chk("slowed", card_clock_slowed, 1);
        // second pass measures one full half period of the slowed pin
        repeat (2) begin
            pin_was = card_clock_pin;
            half = 0;
            while (card_clock_pin === pin_was && half < 20) begin
                tick(1);
                half++;
            end
        end
        chk("slow half period", half, 8);
        acc(1, 8'h20, 32'h1010001, 32'hFDFFFFFF);
        acc(0, 8'h20, 32'h10000, 0);
        acc(0, 8'h10, 32'h80, 0);
        burst <= 4'h5;
        tick(1);
        burst <= 4'h0;
        tick(8);
        chk("stopped", card_clock_stopped, 0);
        tick(10);
        chk("stopped", card_clock_stopped, 1);
        chk("pin", card_clock_pin, 0);
        acc(0, 8'h10, 0, 0);
        burst <= 4'h5;
        tick(1);
        burst <= 4'h0;
        tick(20);
        chk("stopped", card_clock_stopped, 0);
        host_clock_stop_req <= 1'h1;
        tick(3);
        chk("stopped", card_clock_stopped, 1);
        acc(0, 8'h20, 0, 0);
        tick(3);
        chk("stopped", card_clock_stopped, 0);
        avs_byteenable <= 4'h4;
        acc(0, 8'h20, '1, 0);
        avs_byteenable <= 4'hF;
        acc(1, 8'h20, 32'h10000, 32'hFCFFFFFF);
        $display("clock test done");
        acc(0, 8'h10, 32'h37, 0);
        tick(1);
        chk("core", core_supply_request, 3);
        chk("prog", program_supply_request, 7);
        wake_event_enable <= 1'h1;
        rst_n <= 1'h0;
        tick(2);
        rst_n <= 1'h1;
        tick(1);
        chk("core", core_supply_request, 0);
        chk("prog", program_supply_request, 0);
        acc(1, 8'h20, 0, '1);
        wake_event_enable <= 1'h0;
        $display("mid-run reset test done");
        test_done;
    end
    initial begin
        #5000;
        num_errors++;
        test_done;
    end
endmodule
`default_nettype wire
